// [logic/ata_defs.svh]
// offsets, field positions, reset values and counts of the read engine
// assumes a 32-bit register bus with one byte register per aligned word
`ifndef ATA_DEFS_SVH
`define ATA_DEFS_SVH
`define OFF_FEATURE 8'h00
`define OFF_COUNT 8'h04
`define OFF_SECTOR 8'h08
`define OFF_CYL_LOW 8'h0c
`define OFF_CYL_HIGH 8'h10
`define OFF_DEV_HEAD 8'h14
`define OFF_CMD_STATUS 8'h18
`define OFF_ERROR 8'h1c
`define OFF_CONTROL 8'h20
`define OFF_IRQ_STATUS 8'h24
`define OFF_IRQ_MASK 8'h28
`define OFF_QUEUED 8'h2c
`define OP_READ_EXT 8'h25
`define OP_READ_QUEUED 8'h60
`define ST_BSY 7
`define ST_RDY 6
`define ST_DF 5
`define ST_DSC 4
`define ST_DRQ 3
`define ST_ERR 0
`define ER_UNC 6
`define ER_ABT 2
`define CTL_HOB 7
`define IRQ_DONE 0
`define IRQ_FAIL 1
`define RST_BYTE 8'h00
`define MAX_SECTORS 17'h10000
`define WORDS_PER_SECTOR 256
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// [logic/ata_pkg.sv]
// types shared by the read engine and its leaf modules
// assumes nothing beyond a SystemVerilog compiler
package ata_pkg;
  typedef enum logic [1:0] {
    idle_s = 2'b00,
    fetch_s = 2'b01,
    move_s = 2'b10,
    finish_s = 2'b11
  } state_type;
  typedef struct packed {
    logic valid;
    logic [15:0] word;
    logic unc;
  } media_word_type;
  typedef struct packed {
    logic dmarq;
    logic [15:0] word;
  } dma_out_type;
  typedef struct packed {
    logic [7:0] cur;
    logic [7:0] prev;
  } byte_pair_type;
endpackage

// [logic/sector_mover.sv]
// one-word holding stage between media words and the slave dma channel
// assumes dmack comes from logic on the same clock
`timescale 1ns/10ps
`include "ata_defs.svh"
module sector_mover #(
  parameter int WORDS = `WORDS_PER_SECTOR
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable,
  input wire ata_pkg::media_word_type media_in,
  output logic media_ready,
  output ata_pkg::dma_out_type dma_out,
  input wire logic dmack,
  output logic sector_done,
  output logic sector_fail
);
  logic full;
  logic [15:0] word;
  logic [$clog2(WORDS)-1:0] count;
  logic take;

  // a word is taken only while the hold stage is empty
  assign media_ready = enable && !full;
  assign take = media_in.valid && media_ready;
  assign dma_out.dmarq = full;
  assign dma_out.word = word;

  // hold stage fill and drain
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      full <= 1'b0;
    else if (!enable)
      full <= 1'b0;
    else if (take && !media_in.unc)
      full <= 1'b1;
    else if (full && dmack)
      full <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      word <= 16'h0000;
    else if (take && !media_in.unc)
      word <= media_in.word;
  end

  // words per sector and end pulses
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count <= '0;
      sector_done <= 1'b0;
      sector_fail <= 1'b0;
    end
    else
    begin
      sector_done <= 1'b0;
      sector_fail <= enable && take && media_in.unc;
      if (!enable)
        count <= '0;
      else if (full && dmack)
      begin
        count <= count + 1'b1;
        sector_done <= (count == ($clog2(WORDS))'(WORDS - 1));
      end
    end
  end
endmodule

// [logic/irq_block.sv]
// sticky event bits, mask and one level interrupt
// assumes a read of the status word gives a one-cycle clear pulse
`timescale 1ns/10ps
module irq_block #(
  parameter int N = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [N-1:0] event_set,
  input wire logic clear_on_read,
  input wire logic mask_we,
  input wire logic [N-1:0] mask_wdata,
  output logic [N-1:0] status,
  output logic [N-1:0] mask,
  output logic irq
);
  // a new event wins over the read clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status <= '0;
    else
      status <= (clear_on_read ? '0 : status) | event_set;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mask <= '0;
    else if (mask_we)
      mask <= mask_wdata;
  end

  assign irq = |(status & mask);
endmodule

// [logic/ata_dma_read_command.sv]
// taskfile registers and read command engine behind an axi4-lite slave
// assumes media words and dmack come from logic on aclk
`timescale 1ns/10ps
`include "ata_defs.svh"
module ata_dma_read_command #(
  parameter int WORDS = `WORDS_PER_SECTOR
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic media_rd_req,
  output logic [47:0] media_lba,
  input wire ata_pkg::media_word_type media_in,
  output logic media_ready,
  output ata_pkg::dma_out_type dma_out,
  input wire logic dmack,
  output logic irq
);
  ata_pkg::state_type state;
  ata_pkg::byte_pair_type tf [5];
  logic aw_held, w_held, wr_go, rd_go, busy, start, fail, done_event;
  logic [7:0] aw_addr, dev_head, err_bits, control, opcode, rd_byte;
  logic [31:0] w_data;
  logic [3:0] w_strb, wr_idx, rd_idx;
  logic [16:0] remaining, next_remaining;
  logic [47:0] lba, fail_lba, next_lba;
  logic [4:0] tag;
  logic [1:0] prio, irq_status, irq_mask;
  logic sector_done, sector_fail;

  // register index of a byte address, 4'hf when unmapped
  function automatic logic [3:0] reg_index(input logic [7:0] addr);
    case (addr)
      `OFF_FEATURE: reg_index = 4'h0;
      `OFF_COUNT: reg_index = 4'h1;
      `OFF_SECTOR: reg_index = 4'h2;
      `OFF_CYL_LOW: reg_index = 4'h3;
      `OFF_CYL_HIGH: reg_index = 4'h4;
      `OFF_DEV_HEAD: reg_index = 4'h5;
      `OFF_CMD_STATUS: reg_index = 4'h6;
      `OFF_ERROR: reg_index = 4'h7;
      `OFF_CONTROL: reg_index = 4'h8;
      `OFF_IRQ_STATUS: reg_index = 4'h9;
      `OFF_IRQ_MASK: reg_index = 4'ha;
      `OFF_QUEUED: reg_index = 4'hb;
      default: reg_index = 4'hf;
    endcase
  endfunction

  // true for the two read opcodes this engine carries out
  function automatic logic is_read(input logic [7:0] op);
    is_read = (op == `OP_READ_EXT) || (op == `OP_READ_QUEUED);
  endfunction

  // write channel handshakes, address and data in either order
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign wr_go = aw_held && w_held && !s_axi_bvalid;
  assign wr_idx = reg_index(aw_addr);
  assign busy = (state != ata_pkg::idle_s);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (wr_go)
        aw_held <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (wr_go)
        w_held <= 1'b0;
    end
  end

  // write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_idx == 4'hf) ? `RESP_SLVERR : `RESP_OKAY;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // taskfile byte pairs: a write pushes current into previous
  for (genvar g = 0; g < 5; g++)
  begin : tf_pair
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        tf[g] <= '{cur: `RST_BYTE, prev: `RST_BYTE};
      // (g+1)%3 keeps every slice in range, also for g below 2
      else if (g >= 2 && done_event && fail && is_read(opcode))
        tf[g] <= '{cur: fail_lba[8*((g+1)%3)+:8],
                   prev: fail_lba[24+8*((g+1)%3)+:8]};
      else if (wr_go && wr_idx == 4'(g) && w_strb[0] && !busy)
        tf[g] <= '{cur: w_data[7:0], prev: tf[g].cur};
    end
  end

  // plain byte registers written by software
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dev_head <= `RST_BYTE;
      control <= `RST_BYTE;
    end
    else if (wr_go && w_strb[0])
    begin
      if (wr_idx == 4'h5 && !busy)
        dev_head <= w_data[7:0];
      if (wr_idx == 4'h8)
        control <= w_data[7:0];
    end
  end

  // command acceptance and field assembly
  assign start = wr_go && wr_idx == 4'h6 && w_strb[0] && !busy;
  assign next_lba = {tf[4].prev, tf[3].prev, tf[2].prev,
                     tf[4].cur, tf[3].cur, tf[2].cur};
  always_comb
  begin
    if (w_data[7:0] == `OP_READ_QUEUED)
      next_remaining = {1'b0, tf[0].prev, tf[0].cur};
    else
      next_remaining = {1'b0, tf[1].prev, tf[1].cur};
    if (next_remaining == 17'h00000)
      next_remaining = `MAX_SECTORS;
  end

  // queued read tag and priority, kept for software to see
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tag <= 5'h00;
      prio <= 2'b00;
    end
    else if (start && w_data[7:0] == `OP_READ_QUEUED)
    begin
      tag <= tf[1].cur[7:3];
      prio <= tf[1].prev[7:6];
    end
  end

  // command engine
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= ata_pkg::idle_s;
      opcode <= `RST_BYTE;
      lba <= 48'h0;
      remaining <= 17'h0;
      fail <= 1'b0;
      fail_lba <= 48'h0;
      media_rd_req <= 1'b0;
      media_lba <= 48'h0;
    end
    else
    begin
      media_rd_req <= 1'b0;
      case (state)
        ata_pkg::idle_s:
          if (start)
          begin
            opcode <= w_data[7:0];
            lba <= next_lba;
            remaining <= next_remaining;
            fail <= 1'b0;
            if (is_read(w_data[7:0]))
              state <= ata_pkg::fetch_s;
            else
            begin
              fail <= 1'b1;
              state <= ata_pkg::finish_s;
            end
          end
        ata_pkg::fetch_s:
        begin
          media_rd_req <= 1'b1;
          media_lba <= lba;
          state <= ata_pkg::move_s;
        end
        ata_pkg::move_s:
          if (sector_fail)
          begin
            fail <= 1'b1;
            fail_lba <= lba;
            state <= ata_pkg::finish_s;
          end
          else if (sector_done)
          begin
            lba <= lba + 48'h1;
            remaining <= remaining - 17'h1;
            state <= (remaining == 17'h1) ? ata_pkg::finish_s
                                          : ata_pkg::fetch_s;
          end
        ata_pkg::finish_s:
          state <= ata_pkg::idle_s;
        default:
          state <= ata_pkg::idle_s;
      endcase
    end
  end

  assign done_event = (state == ata_pkg::finish_s);

  // error cause bits set at the end of a command
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      err_bits <= 8'h00;
    else if (start)
      err_bits <= 8'h00;
    else if (done_event && fail)
    begin
      err_bits[`ER_UNC] <= is_read(opcode);
      err_bits[`ER_ABT] <= !is_read(opcode);
    end
  end

  sector_mover #(.WORDS(WORDS)) mover (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(state == ata_pkg::move_s),
    .media_in(media_in),
    .media_ready(media_ready),
    .dma_out(dma_out),
    .dmack(dmack),
    .sector_done(sector_done),
    .sector_fail(sector_fail)
  );

  // read channel
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign rd_idx = reg_index(s_axi_araddr);

  irq_block #(.N(2)) irqs (
    .aclk(aclk),
    .aresetn(aresetn),
    .event_set({done_event && fail, done_event}),
    .clear_on_read(rd_go && rd_idx == 4'h9),
    .mask_we(wr_go && wr_idx == 4'ha && w_strb[0]),
    .mask_wdata(w_data[1:0]),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq)
  );

  // read data selection, hob picks the previous byte
  always_comb
  begin
    rd_byte = 8'h00;
    case (rd_idx)
      4'h0, 4'h1, 4'h2, 4'h3, 4'h4:
        rd_byte = control[`CTL_HOB] ? tf[rd_idx[2:0]].prev
                                    : tf[rd_idx[2:0]].cur;
      4'h5: rd_byte = dev_head;
      4'h6:
      begin
        rd_byte[`ST_BSY] = busy;
        rd_byte[`ST_RDY] = 1'b1;
        rd_byte[`ST_DSC] = 1'b1;
        rd_byte[`ST_DRQ] = dma_out.dmarq;
        rd_byte[`ST_ERR] = |err_bits;
      end
      4'h7: rd_byte = err_bits;
      4'h8: rd_byte = control;
      4'h9: rd_byte = {6'h00, irq_status};
      4'ha: rd_byte = {6'h00, irq_mask};
      4'hb: rd_byte = {tag, 1'b0, prio};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else if (rd_go)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= (rd_idx == 4'hf) ? `RESP_SLVERR : `RESP_OKAY;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence fail_end;
    state == ata_pkg::finish_s ##1 state == ata_pkg::idle_s;
  endsequence
  a_single_done: assert property (done_event |=> !done_event)
    else $error("completion event lasted more than one cycle");
  a_dmarq_in_move: assert property (dma_out.dmarq
    |-> state == ata_pkg::move_s)
    else $error("dmarq outside the transfer state");
  a_fail_stops: assert property (sector_fail && state == ata_pkg::move_s
    |=> fail_end ##1 !dma_out.dmarq)
    else $error("transfer went on after a failing sector");
  a_zero_count_max: assert property (start && next_remaining[15:0] == 0
    |=> remaining == `MAX_SECTORS)
    else $error("zero count not taken as 65536");
  a_ext_count: assert property (start && w_data[7:0] == `OP_READ_EXT
    && {tf[1].prev, tf[1].cur} != 16'h0
    |=> remaining[15:0] == $past({tf[1].prev, tf[1].cur}))
    else $error("extended count not assembled from count bytes");
  a_queued_count: assert property (start && w_data[7:0] == `OP_READ_QUEUED
    && {tf[0].prev, tf[0].cur} != 16'h0
    |=> remaining[15:0] == $past({tf[0].prev, tf[0].cur}))
    else $error("queued count not taken from feature bytes");
  a_lba_build: assert property (start |=> lba == $past(next_lba))
    else $error("start address assembled wrongly");
  a_fail_lba_back: assert property (done_event && fail
    && err_bits == 8'h00 && opcode == `OP_READ_EXT
    |=> {tf[4].prev, tf[3].prev, tf[2].prev,
         tf[4].cur, tf[3].cur, tf[2].cur} == fail_lba)
    else $error("failing address not returned");
  a_end_status: assert property (done_event
    |=> !busy ##0 (|err_bits == $past(fail)))
    else $error("end status wrong");
endmodule

// [tb/dma_host_model.sv]
// host slave dma channel model: acknowledges dmarq words and counts them
// assumes dma_out and dmack live on aclk and the channel is armed first
`timescale 1ns/10ps
module dma_host_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire ata_pkg::dma_out_type dma_out,
  input wire logic armed,
  input wire logic slow,
  output logic dmack,
  output int n_words,
  output logic [15:0] last_word
);
  logic phase;
  // ack armed requests only; slow mode stalls every other cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dmack <= 1'b0;
      phase <= 1'b0;
      n_words <= 0;
      last_word <= 16'h0000;
    end
    else
    begin
      phase <= ~phase;
      dmack <= armed && dma_out.dmarq && (!slow || phase);
      if (dma_out.dmarq && dmack)
      begin
        n_words <= n_words + 1;
        last_word <= dma_out.word;
      end
    end
  end
endmodule

// [tb/ata_dma_read_command_bench.sv]
// bench of the read engine: axi4-lite tasks, media source, checks
// assumes the host dma model beside it and a 40 mhz aclk
`timescale 1ns/10ps
`include "ata_defs.svh"
module ata_dma_read_command_bench;
  localparam int W = 4;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h1;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic armed = 1'b0;
  logic slow = 1'b0;
  logic serving = 1'b0;
  logic [7:0] widx = 8'h00;
  logic awready, wready, bvalid, arready, rvalid;
  logic media_rd_req, media_ready, dmack, irq;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, d;
  logic [47:0] media_lba, first_lba, l;
  logic [15:0] last_word;
  ata_pkg::media_word_type media_in;
  ata_pkg::dma_out_type dma_out;
  int err_count = 0;
  int n_compared = 0;
  int n_req = 0;
  int bad_req = -1;
  int base = 0;
  int wbase = 0;
  int n_words, i, j;
  // 25 ns clock
  initial
  begin
    forever #12.5 aclk = ~aclk;
  end
  ata_dma_read_command #(.WORDS(W)) ata_dma_read_command_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid),
    .s_axi_awready(awready),
    .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid),
    .s_axi_wready(wready),
    .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid),
    .s_axi_bready(bready),
    .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid),
    .s_axi_arready(arready),
    .s_axi_rdata(rdata),
    .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid),
    .s_axi_rready(rready),
    .media_rd_req(media_rd_req),
    .media_lba(media_lba),
    .media_in(media_in),
    .media_ready(media_ready),
    .dma_out(dma_out),
    .dmack(dmack),
    .irq(irq)
  );
  dma_host_model dma_host_model_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .dma_out(dma_out),
    .armed(armed),
    .slow(slow),
    .dmack(dmack),
    .n_words(n_words),
    .last_word(last_word)
  );
  // media source: W words per fetch, bad first word on the chosen fetch
  always @(posedge aclk)
  begin
    if (media_rd_req)
    begin
      if (n_req == base) first_lba <= media_lba;
      n_req <= n_req + 1;
      widx <= 8'h00;
      serving <= 1'b1;
    end
    else if (media_in.valid && media_ready)
    begin
      widx <= widx + 8'h01;
      if (media_in.unc || widx == W - 1) serving <= 1'b0;
    end
  end
  // idle lines carry the inverse pattern
  assign media_in = {serving,
    serving ? {8'(n_req - 1), widx} : ~{8'(n_req), widx},
    serving && widx == 8'h00 && n_req - 1 == bad_req};
  task stop_test;
    begin
      $display("counts: %0d compared, %0d bad", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task hang;
    begin
      err_count++;
      $display("BAD %0t wait ran out", $time);
      stop_test;
    end
  endtask
  task chk(input logic [47:0] got, input logic [47:0] exp);
    begin
      n_compared++;
      if (got !== exp)
      begin
        err_count++;
        $display("BAD %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // axi4-lite write: address and data together, bready up until bvalid
  task wr(input logic [7:0] a, input logic [7:0] v);
    int n;
    logic got;
    begin
      got = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h000000, v};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 64 && !got; n++)
      begin
        @(posedge aclk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        if (bvalid)
        begin
          bready <= 1'b0;
          resp = bresp;
          got = 1'b1;
        end
      end
      if (!got) hang;
    end
  endtask
  // axi4-lite read into d and resp
  task rd(input logic [7:0] a);
    int n;
    logic got;
    begin
      got = 1'b0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 64 && !got; n++)
      begin
        @(posedge aclk);
        if (arready) arvalid <= 1'b0;
        if (rvalid)
        begin
          rready <= 1'b0;
          d = rdata;
          resp = rresp;
          got = 1'b1;
        end
      end
      if (!got) hang;
    end
  endtask
  task rc(input logic [7:0] a, input logic [47:0] e);
    begin
      rd(a);
      chk(d, e);
    end
  endtask
  // poll status until busy drops
  task idle;
    int n;
    begin
      d = 32'h80;
      for (n = 0; n < 500 && d[7] !== 1'b0; n++) rd(`OFF_CMD_STATUS);
      if (d[7] !== 1'b0) hang;
    end
  endtask
  // address pairs: previous byte first, then current
  task setup(input logic [47:0] a, input logic [7:0] r,
    input logic [15:0] c);
    int k;
    begin
      for (k = 0; k < 3; k++)
      begin
        wr(8'(8 + 4 * k), a[24 + 8 * k +: 8]);
        wr(8'(8 + 4 * k), a[8 * k +: 8]);
      end
      wr(r, c[15:8]);
      wr(r, c[7:0]);
    end
  endtask
  task run(input logic [7:0] op, input logic poke);
    begin
      base = n_req;
      wbase = n_words;
      armed <= 1'b1;
      wr(`OFF_CMD_STATUS, op);
      if (poke) wr(`OFF_CMD_STATUS, `OP_READ_QUEUED);
      idle;
    end
  endtask
  // main sequence
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rc(`OFF_CMD_STATUS, 32'h50);
    rc(`OFF_IRQ_MASK, 32'h0);
    rc(8'h40, 32'h0);
    chk(resp, `RESP_SLVERR);
    wr(8'h40, 8'h01);
    chk(resp, `RESP_SLVERR);
    wstrb <= 4'h0;
    wr(`OFF_IRQ_MASK, 8'h03);
    rc(`OFF_IRQ_MASK, 32'h0);
    wstrb <= 4'h1;
    $display("test registers done");
    // two sectors, interrupt masked, second command refused
    l = 48'h665544332211;
    setup(l, `OFF_COUNT, 16'h0002);
    wr(`OFF_CONTROL, 8'h80);
    rc(`OFF_SECTOR, 32'h44);
    rc(`OFF_COUNT, 32'h0);
    wr(`OFF_CONTROL, 8'h00);
    run(`OP_READ_EXT, 1'b1);
    chk(first_lba, l);
    chk(n_req - base, 2);
    chk(n_words - wbase, 2 * W);
    chk(last_word, {8'(base + 1), 8'(W - 1)});
    rc(`OFF_CMD_STATUS, 32'h50);
    @(negedge aclk);
    chk(irq, 1'b0);
    wr(`OFF_IRQ_MASK, 8'h03);
    @(negedge aclk);
    chk(irq, 1'b1);
    rc(`OFF_IRQ_STATUS, 32'h1);
    @(negedge aclk);
    chk(irq, 1'b0);
    rc(`OFF_IRQ_STATUS, 32'h0);
    $display("test two sectors done");
    // zero count runs long; a bad fourth sector stops it
    l = 48'ha1b2c3d4e5f0;
    slow <= 1'b1;
    setup(l, `OFF_COUNT, 16'h0000);
    bad_req = n_req + 3;
    run(`OP_READ_EXT, 1'b0);
    chk(n_words - wbase, 3 * W);
    chk(n_req - base, 4);
    rc(`OFF_ERROR, 32'h40);
    rc(`OFF_CMD_STATUS, 32'h51);
    rc(`OFF_IRQ_STATUS, 32'h3);
    l = l + 48'h3;
    for (i = 0; i < 2; i++)
    begin
      wr(`OFF_CONTROL, {i[0], 7'h00});
      for (j = 0; j < 3; j++)
        rc(8'(8 + 4 * j), l[24 * i + 8 * j +: 8]);
    end
    wr(`OFF_CONTROL, 8'h00);
    bad_req = -1;
    $display("test media error done");
    // queued reads, one each for priority codes 0 to 2
    for (i = 0; i < 3; i++)
    begin
      l = 48'h010203040500 + 48'(16 * i);
      setup(l, `OFF_FEATURE, 16'(i + 1));
      wr(`OFF_COUNT, 8'(i << 6));
      wr(`OFF_COUNT, 8'((i + 1) << 3));
      run(`OP_READ_QUEUED, 1'b0);
      chk(first_lba, l);
      chk(n_words - wbase, (i + 1) * W);
      rc(`OFF_QUEUED, 8'(((i + 1) << 3) | i));
      rc(`OFF_IRQ_STATUS, 32'h1);
    end
    $display("test queued done");
    // unknown opcode aborts
    run(8'h00, 1'b0);
    rc(`OFF_ERROR, 32'h04);
    rc(`OFF_CMD_STATUS, 32'h51);
    rc(`OFF_SECTOR, 32'h20);
    $display("test abort done");
    stop_test;
  end
endmodule
